// *** rtl/flash_host_defs.svh ***
// constants for the flash host controller: command codes, addresses, timing
// assumes a 125 MHz system clock and a 1M x16 flash on the far side
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define UNLOCK_ADDR1     20'h00555
`define UNLOCK_ADDR2     20'h002AA
`define UNLOCK_DATA1     16'h00AA
`define UNLOCK_DATA2     16'h0055
`define CMD_PROGRAM      16'h00A0
`define CMD_ERASE_SETUP  16'h0080
`define CMD_SECTOR_ERASE 16'h0050
`define CMD_BLOCK_ERASE  16'h0030
`define CMD_CHIP_ERASE   16'h0010
`define CMD_ID_ENTRY     16'h0090
`define CMD_CFI_ENTRY    16'h0098
`define CMD_SEC_ENTRY    16'h0088
`define CMD_SEC_PROGRAM  16'h00A5
`define CMD_SEC_LOCK     16'h0085
`define CMD_MODE_EXIT    16'h00F0
`define CFI_SHORT_ADDR   20'h00055
`define CFI_SHORT_DATA   16'h0089
`define SEC_LOCK_DATA    16'h0000
`define SECTOR_LSB       11
`define BLOCK_LSB        15
`define BOOT_TOP_BASE    20'hFE000
`define BOOT_BOT_LAST    20'h01FFF
`define SEC_SPACE_WORDS  136
`define SEC_USER_BASE    8'h08
// strobe low and recovery phases of one bus cycle, ns
`define STROBE_NS        40
`define CLK_NS           8
`define STROBE_CYC       ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define ID_ADDR_MAKER    20'h00000
`define ID_ADDR_DEVICE   20'h00001

`endif

// *** rtl/flash_host_pkg.sv ***
// types for the flash host controller
// shared by the controller and the verification side
package flash_host_pkg;
  typedef enum logic [3:0]
  {
    OP_READ        = 4'h0,
    OP_PROGRAM     = 4'h1,
    OP_SECTOR_ERASE= 4'h2,
    OP_BLOCK_ERASE = 4'h3,
    OP_CHIP_ERASE  = 4'h4,
    OP_ID_ENTRY    = 4'h5,
    OP_CFI_ENTRY   = 4'h6,
    OP_CFI_SHORT   = 4'h7,
    OP_SEC_ENTRY   = 4'h8,
    OP_SEC_PROGRAM = 4'h9,
    OP_SEC_LOCK    = 4'hA,
    OP_MODE_EXIT   = 4'hB
  } op_e;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_WAIT  = 3'b100,
    ST_DONE  = 3'b101
  } state_e;

  typedef enum logic [1:0]
  {
    MODE_ARRAY = 2'b00,
    MODE_ID    = 2'b01,
    MODE_CFI   = 2'b10,
    MODE_SEC   = 2'b11
  } mode_e;
endpackage

// *** rtl/flash_host_ctrl.sv ***
// host-side controller that drives a parallel x16 flash through its pins
// assumes flash pins are sampled synchronously to clk; ready_busy_od has a pull-up
`timescale 1ns/1ps
`include "flash_host_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int unsigned STROBE = `STROBE_CYC
)
(
  input  wire logic        clk,          // system clock
  input  wire logic        rst_b,        // async reset, active low
  input  wire logic        req,          // start an operation
  input  wire op_e         op,           // operation code
  input  wire logic [19:0] addr,         // word address
  input  wire logic [15:0] wdata,        // write data
  input  wire logic        wp_level,     // level to hold on write protect
  output logic             ack,          // operation finished, one cycle
  output logic             busy,         // controller busy
  output logic [15:0]      rdata,        // read data
  output logic [1:0]       mode,         // mode the flash is believed in
  output logic             refused,      // op refused, one cycle
  output logic [19:0]      fl_addr,      // flash address pins
  output logic             fl_ce_b,      // chip enable
  output logic             fl_oe_b,      // output enable
  output logic             fl_we_b,      // write enable
  output logic             fl_wp_b,      // write protect
  output logic             fl_rst_b,     // flash hardware reset
  input  wire logic [15:0] fl_dq_i,      // data from flash
  output logic [15:0]      fl_dq_o,      // data to flash
  output logic             fl_dq_oe,     // host drives data bus
  input  wire logic        ready_busy_od // open-drain busy, low while busy
);

  ////////////////////////////////////////////////////////////////////////////
  // sequence tables
  localparam int unsigned CW = 8;
  state_e       st_q;
  op_e          op_q;
  logic [19:0]  addr_q;
  logic [15:0]  data_q;
  logic [2:0]   idx_q;
  logic [CW-1:0] cnt_q;
  mode_e        mode_q;
  logic         tog_q;
  logic         tog_seen_q;

  function automatic logic [2:0] seq_len(input op_e o);
    case (o)
      OP_READ:         seq_len = 3'd0;
      OP_CFI_SHORT:    seq_len = 3'd1;
      OP_MODE_EXIT:    seq_len = 3'd1;
      OP_ID_ENTRY, OP_CFI_ENTRY, OP_SEC_ENTRY: seq_len = 3'd3;
      OP_PROGRAM, OP_SEC_PROGRAM, OP_SEC_LOCK:  seq_len = 3'd4;
      default:         seq_len = 3'd6;
    endcase
  endfunction

  function automatic logic [35:0] seq_word(input op_e o, input logic [2:0] i,
                                           input logic [19:0] a,
                                           input logic [15:0] d);
    logic [15:0] c;
    c = `CMD_ERASE_SETUP;
    case (o)
      OP_PROGRAM:     c = `CMD_PROGRAM;
      OP_ID_ENTRY:    c = `CMD_ID_ENTRY;
      OP_CFI_ENTRY:   c = `CMD_CFI_ENTRY;
      OP_SEC_ENTRY:   c = `CMD_SEC_ENTRY;
      OP_SEC_PROGRAM: c = `CMD_SEC_PROGRAM;
      OP_SEC_LOCK:    c = `CMD_SEC_LOCK;
      default:        c = `CMD_ERASE_SETUP;
    endcase
    if (o == OP_CFI_SHORT)
      seq_word = {`CFI_SHORT_ADDR, `CFI_SHORT_DATA};
    else if (o == OP_MODE_EXIT)
      seq_word = {`UNLOCK_ADDR1, `CMD_MODE_EXIT};
    else
      case (i)
        3'd0, 3'd3: seq_word = (i == 3'd3 && seq_len(o) == 3'd4) ?
                               {a, (o == OP_SEC_LOCK) ? `SEC_LOCK_DATA : d} :
                               {`UNLOCK_ADDR1, `UNLOCK_DATA1};
        3'd1, 3'd4: seq_word = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
        3'd2:       seq_word = {`UNLOCK_ADDR1, c};
        default:
        case (o)
          OP_SECTOR_ERASE: seq_word = {a[19:`SECTOR_LSB], `SECTOR_LSB'(0),
                                       `CMD_SECTOR_ERASE};
          OP_BLOCK_ERASE:  seq_word = {a[19:`BLOCK_LSB], `BLOCK_LSB'(0),
                                       `CMD_BLOCK_ERASE};
          default:         seq_word = {`UNLOCK_ADDR1, `CMD_CHIP_ERASE};
        endcase
      endcase
  endfunction

  function automatic logic writes_array(input op_e o);
    writes_array = (o == OP_PROGRAM) || (o == OP_SECTOR_ERASE) ||
                   (o == OP_BLOCK_ERASE) || (o == OP_CHIP_ERASE) ||
                   (o == OP_SEC_PROGRAM) || (o == OP_SEC_LOCK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer
  logic [35:0] cur;
  logic        ok_mode;
  assign cur = seq_word(op_q, idx_q, addr_q, data_q);
  // mode entry only from array read; exit only from a mode; read and sec program/lock anywhere; other writes only from array read
  assign ok_mode = (op == OP_MODE_EXIT) ? (mode_q != MODE_ARRAY) :
                   (op == OP_ID_ENTRY || op == OP_CFI_ENTRY ||
                    op == OP_CFI_SHORT || op == OP_SEC_ENTRY) ?
                   (mode_q == MODE_ARRAY) :
                   (op == OP_READ) || (op == OP_SEC_PROGRAM) ||
                   (op == OP_SEC_LOCK) || (mode_q == MODE_ARRAY);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q    <= ST_IDLE;
      op_q    <= OP_READ;
      addr_q  <= 20'h00000;
      data_q  <= 16'h0000;
      idx_q   <= 3'd0;
      cnt_q   <= '0;
      ack     <= 1'b0;
      refused <= 1'b0;
      rdata   <= 16'h0000;
    end
    else
    begin
      ack     <= 1'b0;
      refused <= 1'b0;
      case (st_q)
        ST_IDLE:
          if (req)
          begin
            if (!ok_mode || ready_busy_od == 1'b0)
              refused <= 1'b1;
            else
            begin
              op_q   <= op;
              addr_q <= addr;
              data_q <= wdata;
              idx_q  <= 3'd0;
              cnt_q  <= CW'(STROBE);
              st_q   <= ST_SETUP;
            end
          end
        ST_SETUP:
          st_q <= ST_LOW;
        ST_LOW:
          if (cnt_q == CW'(1))
          begin
            if (op_q == OP_READ)
              rdata <= fl_dq_i;
            cnt_q <= CW'(STROBE);
            st_q  <= ST_HIGH;
          end
          else
            cnt_q <= cnt_q - CW'(1);
        ST_HIGH:
          if (cnt_q == CW'(1))
          begin
            if (op_q != OP_READ && idx_q + 3'd1 < seq_len(op_q))
            begin
              idx_q <= idx_q + 3'd1;
              cnt_q <= CW'(STROBE);
              st_q  <= ST_SETUP;
            end
            else
              st_q <= writes_array(op_q) ? ST_WAIT : ST_DONE;
          end
          else
            cnt_q <= cnt_q - CW'(1);
        ST_WAIT:
          if (ready_busy_od)
            st_q <= ST_DONE;
        ST_DONE:
        begin
          ack  <= 1'b1;
          st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // believed flash mode; reset of the flash returns it to array read
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_q <= MODE_ARRAY;
    else if (st_q == ST_DONE)
      case (op_q)
        OP_ID_ENTRY:                 mode_q <= MODE_ID;
        OP_CFI_ENTRY, OP_CFI_SHORT:  mode_q <= MODE_CFI;
        OP_SEC_ENTRY:                mode_q <= MODE_SEC;
        OP_MODE_EXIT:                mode_q <= MODE_ARRAY;
        default:                     mode_q <= mode_q;
      endcase
  end

  // toggle bit watch: a second read differing in bit 6 means still busy
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tog_q      <= 1'b0;
      tog_seen_q <= 1'b0;
    end
    else if (st_q == ST_LOW && cnt_q == CW'(1) && op_q == OP_READ)
    begin
      tog_q      <= fl_dq_i[6];
      tog_seen_q <= tog_q ^ fl_dq_i[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins; upper data bits driven with the command word, never floating
  assign fl_addr  = (op_q == OP_READ) ? addr_q : cur[35:16];
  assign fl_ce_b  = !(st_q == ST_SETUP || st_q == ST_LOW);
  assign fl_oe_b  = !(op_q == OP_READ && st_q == ST_LOW);
  assign fl_we_b  = !(op_q != OP_READ && st_q == ST_LOW);
  assign fl_dq_o  = cur[15:0];
  assign fl_dq_oe = (op_q != OP_READ) && (st_q == ST_SETUP || st_q == ST_LOW ||
                                          st_q == ST_HIGH);
  assign fl_wp_b  = wp_level;
  assign fl_rst_b = rst_b;
  assign busy     = (st_q != ST_IDLE);
  assign mode     = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_we_oe_excl;
    @(posedge clk) disable iff (!rst_b) !(fl_we_b == 1'b0 && fl_oe_b == 1'b0);
  endproperty
  a_we_oe_excl: assert property (p_we_oe_excl) else $error("we and oe both low");

  property p_drive_while_we;
    @(posedge clk) disable iff (!rst_b) !fl_we_b |-> fl_dq_oe;
  endproperty
  a_drive_while_we: assert property (p_drive_while_we) else $error("data undriven");

  property p_unlock_first;
    @(posedge clk) disable iff (!rst_b)
      ($fell(fl_we_b) && idx_q == 3'd0 && op_q == OP_PROGRAM) |->
      (fl_dq_o == `UNLOCK_DATA1 && fl_addr == `UNLOCK_ADDR1);
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("no unlock");

  property p_erase_last;
    @(posedge clk) disable iff (!rst_b)
      ($fell(fl_we_b) && idx_q == 3'd5) |-> fl_dq_o[7:0] inside {8'h50, 8'h30, 8'h10};
  endproperty
  a_erase_last: assert property (p_erase_last) else $error("bad erase code");

  property p_refuse_busy;
    @(posedge clk) disable iff (!rst_b)
      (st_q == ST_IDLE && req && !ready_busy_od) |=> refused && st_q == ST_IDLE;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy) else $error("busy not refused");

  property p_wait_busy;
    @(posedge clk) disable iff (!rst_b)
      (st_q == ST_WAIT && !ready_busy_od) |=> st_q == ST_WAIT;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("left wait early");

  property p_mode_entry;
    @(posedge clk) disable iff (!rst_b)
      (mode_q != MODE_ARRAY && $changed(mode_q)) |-> $past(mode_q) == MODE_ARRAY;
  endproperty
  a_mode_entry: assert property (p_mode_entry) else $error("mode hop");

  property p_sector_addr;
    @(posedge clk) disable iff (!rst_b)
      ($fell(fl_we_b) && idx_q == 3'd5 && op_q == OP_SECTOR_ERASE) |->
      fl_addr[10:0] == 11'h000 && fl_addr[19:11] == addr_q[19:11];
  endproperty
  a_sector_addr: assert property (p_sector_addr) else $error("bad sector addr");

endmodule

// *** verification/flash_dev_model.sv ***
// behavioural x16 top-boot flash part that faces the host controller
// assumes host pins settle between clk edges; ready line has a pull-up
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 12,
  parameter logic [15:0] MAKER    = 16'h00A1, // arbitrary value
  parameter logic [15:0] DEVICE   = 16'h7E01, // arbitrary value
  parameter logic [15:0] CFI_WORD = 16'h0051,
  parameter logic [15:0] SEC_SEED = 16'h5A00
)
(
  input  wire logic        clk,   // bench clock
  input  wire logic        rst_b, // hardware reset pin
  input  wire logic [19:0] addr,  // address pins
  input  wire logic        ce_b,  // chip enable
  input  wire logic        oe_b,  // output enable
  input  wire logic        we_b,  // write enable
  input  wire logic        wp_b,  // write protect
  input  wire logic [15:0] dq,    // resolved data bus
  output logic      [15:0] dq_o,  // data from the part
  output logic             dq_oe, // part drives the bus
  output logic             rb_low // pulls ready line low
);
  logic [15:0] mem [0:20'hFFFFF];
  logic [15:0] sec [0:`SEC_SPACE_WORDS-1];
  mode_e       mode_q;
  logic [3:0]  step_q;
  logic [7:0]  busy_q;
  logic [19:0] a_q;
  logic [19:0] m;
  logic        wr_q;
  logic        rd_q;
  logic        tgl_q;
  logic        lock_q;
  logic [15:0] last_q;
  logic [15:0] val;
  wire         wr_n = we_b | ce_b;
  wire         prot = !wp_b && a_q >= `BOOT_TOP_BASE;

  function automatic logic [19:0] blk(input logic [19:0] a);
    if (a >= 20'hFE000) return 20'hFE000;
    if (a >= 20'hFC000) return 20'hFF000;
    if (a >= 20'hF8000) return 20'hFC000;
    return 20'hF8000;
  endfunction

  initial
  begin
    lock_q = 1'b0;
    for (int i = 0; i <= 20'hFFFFF; i++) mem[i] = 16'hFFFF;
    for (int i = 0; i < `SEC_SPACE_WORDS; i++) sec[i] = (i < 8) ? SEC_SEED + 16'(i) : 16'hFFFF;
  end

  always_comb
  begin
    if (busy_q != 8'h00) val = {9'h000, tgl_q, 6'h00};
    else if (mode_q == MODE_ID) val = (addr == `ID_ADDR_MAKER) ? MAKER : DEVICE;
    else if (mode_q == MODE_CFI) val = CFI_WORD;
    else if (mode_q == MODE_SEC) val = (addr < 136) ? sec[addr[7:0]] : 16'hFFFF;
    else val = mem[addr];
  end
  assign dq_oe  = !ce_b && !oe_b;
  // a released bus shows the inverse of its last value, never a kind zero
  assign dq_o   = dq_oe ? val : ~last_q;
  assign rb_low = busy_q != 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      mode_q <= MODE_ARRAY;
      step_q <= 4'h0;
      busy_q <= 8'h00;
      wr_q   <= 1'b1;
      rd_q   <= 1'b1;
      tgl_q  <= 1'b0;
    end
    else
    begin
      wr_q   <= wr_n;
      rd_q   <= oe_b | ce_b;
      last_q <= dq;
      if (busy_q != 8'h00) busy_q <= busy_q - 8'h01;
      if (busy_q != 8'h00 && !(oe_b | ce_b) && rd_q) tgl_q <= !tgl_q;
      if (!wr_n && wr_q) a_q <= addr;
      if (wr_n && !wr_q && busy_q == 8'h00)
      begin
        step_q <= 4'h0;
        case (step_q)
          4'h0:
            if (a_q == `UNLOCK_ADDR1 && dq == `UNLOCK_DATA1) step_q <= 4'h1;
            else if (a_q == `CFI_SHORT_ADDR && dq == `CFI_SHORT_DATA && mode_q == MODE_ARRAY)
              mode_q <= MODE_CFI;
            else if (dq == `CMD_MODE_EXIT) mode_q <= MODE_ARRAY;
          4'h1, 4'h7:
            if (a_q == `UNLOCK_ADDR2 && dq == `UNLOCK_DATA2) step_q <= step_q + 4'h1;
            else mode_q <= MODE_ARRAY;
          4'h6:
            if (a_q == `UNLOCK_ADDR1 && dq == `UNLOCK_DATA1) step_q <= 4'h7;
            else mode_q <= MODE_ARRAY;
          4'h2:
            if (a_q != `UNLOCK_ADDR1) mode_q <= MODE_ARRAY;
            else
              case (dq)
                `CMD_PROGRAM:     step_q <= 4'h3;
                `CMD_SEC_PROGRAM: step_q <= 4'h4;
                `CMD_SEC_LOCK:    step_q <= 4'h5;
                `CMD_ERASE_SETUP: step_q <= 4'h6;
                `CMD_ID_ENTRY:    if (mode_q == MODE_ARRAY) mode_q <= MODE_ID;
                `CMD_CFI_ENTRY:   if (mode_q == MODE_ARRAY) mode_q <= MODE_CFI;
                `CMD_SEC_ENTRY:   if (mode_q == MODE_ARRAY) mode_q <= MODE_SEC;
                default:          mode_q <= MODE_ARRAY;
              endcase
          4'h3:
          begin
            if (!prot) mem[a_q] = mem[a_q] & dq;
            busy_q <= 8'(BUSY_CYC);
          end
          4'h4:
          begin
            if (!lock_q && a_q >= `SEC_USER_BASE && a_q < 136)
              sec[a_q[7:0]] = sec[a_q[7:0]] & dq;
            busy_q <= 8'(BUSY_CYC);
          end
          4'h5:
            if (dq == `SEC_LOCK_DATA) lock_q <= 1'b1;
          4'h8:
          begin
            m = (dq == `CMD_SECTOR_ERASE) ? 20'hFF800 : blk(a_q);
            if (dq == `CMD_CHIP_ERASE) m = 20'h00000;
            // erase never touches the security space
            if ((dq == `CMD_CHIP_ERASE) ? (a_q == `UNLOCK_ADDR1 && wp_b) :
                ((dq == `CMD_SECTOR_ERASE || dq == `CMD_BLOCK_ERASE) && !prot))
            begin
              for (int i = 0; i <= 20'hFFFFF; i++)
                if ((20'(i) & m) == (a_q & m)) mem[i] = 16'hFFFF;
              busy_q <= 8'(BUSY_CYC);
            end
            else mode_q <= MODE_ARRAY;
          end
          default: step_q <= 4'h0;
        endcase
      end
    end
endmodule

// *** verification/tb_flash_command_mode_logic.sv ***
// self-checking bench for the flash host controller
// assumes the device model on the far side and STROBE shortened to 1
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module tb_flash_command_mode_logic;
  import flash_host_pkg::*;
  typedef struct {op_e op; logic [19:0] a; logic [15:0] d; logic wp; logic [15:0] e; logic [1:0] md;} row_s;
  localparam logic [15:0] MAKER = 16'h00A1; // arbitrary value
  localparam logic [15:0] DEV   = 16'h7E01; // arbitrary value
  logic        clk, rst_b, req, wp_level, ack, busy, refused, rf;
  op_e         op;
  logic [19:0] addr, fl_addr;
  logic [15:0] wdata, rdata, fl_dq_o, dev_dq;
  logic [1:0]  mode;
  logic        fl_ce_b, fl_oe_b, fl_we_b, fl_wp_b, fl_rst_b, fl_dq_oe, dev_oe, rb_low;
  wire  [15:0] bus = fl_dq_oe ? fl_dq_o : dev_dq;
  wire         rdy = rb_low ? 1'b0 : 1'b1;
  row_s        rows[$];
  int          err_total, check_count, n;

  flash_host_ctrl #(.STROBE(1)) flash_host_ctrl_inst (.clk(clk), .rst_b(rst_b), .req(req),
    .op(op), .addr(addr), .wdata(wdata), .wp_level(wp_level), .ack(ack), .busy(busy),
    .rdata(rdata), .mode(mode), .refused(refused), .fl_addr(fl_addr), .fl_ce_b(fl_ce_b),
    .fl_oe_b(fl_oe_b), .fl_we_b(fl_we_b), .fl_wp_b(fl_wp_b), .fl_rst_b(fl_rst_b),
    .fl_dq_i(bus), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .ready_busy_od(rdy));
  flash_dev_model #(.MAKER(MAKER), .DEVICE(DEV)) flash_dev_model_inst (.clk(clk),
    .rst_b(fl_rst_b), .addr(fl_addr), .ce_b(fl_ce_b), .oe_b(fl_oe_b), .we_b(fl_we_b),
    .wp_b(fl_wp_b), .dq(bus), .dq_o(dev_dq), .dq_oe(dev_oe), .rb_low(rb_low));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task add(op_e o, logic [19:0] a, logic [15:0] d, logic wp, logic [15:0] e, logic [1:0] md);
    rows.push_back('{o, a, d, wp, e, md});
  endtask

  // one request, held until the take edge; waits for ack or refused, bounded
  // refused stands only in the cycle right after the take edge, so look there first
  task do_op(input op_e o, input logic [19:0] a, input logic [15:0] d, output logic r);
    @(posedge clk);
    req   <= 1'b1;
    op    <= o;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    #1;
    while (ack !== 1'b1 && refused !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000)
      err_total++;
    r = refused;
  endtask

  // the bus must never be driven from both ends at once
  always @(negedge clk)
    if (fl_dq_oe === 1'b1)
      check(16'(dev_oe), 16'h0000);

  initial
  begin
    #200000;
    err_total++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0; req = 1'b0; op = OP_READ; addr = 20'h00000; wdata = 16'h0000; wp_level = 1'b1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    add(OP_PROGRAM, 20'h00100, 16'h1234, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'h00100, 16'h0000, 1'b1, 16'h1234, 2'h0);
    add(OP_ID_ENTRY, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h1);
    add(OP_READ, `ID_ADDR_MAKER, 16'h0000, 1'b1, MAKER, 2'h1);
    add(OP_READ, `ID_ADDR_DEVICE, 16'h0000, 1'b1, DEV, 2'h1);
    add(OP_MODE_EXIT, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'h00100, 16'h0000, 1'b1, 16'h1234, 2'h0);
    add(OP_CFI_ENTRY, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h2);
    add(OP_READ, 20'h00010, 16'h0000, 1'b1, 16'h0051, 2'h2);
    add(OP_MODE_EXIT, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_CFI_SHORT, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h2);
    add(OP_READ, 20'h00020, 16'h0000, 1'b1, 16'h0051, 2'h2);
    add(OP_MODE_EXIT, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_SEC_ENTRY, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h3);
    add(OP_READ, 20'h00000, 16'h0000, 1'b1, 16'h5A00, 2'h3);
    add(OP_SEC_PROGRAM, 20'h00008, 16'h00A5, 1'b1, 16'h0000, 2'h3);
    add(OP_READ, 20'h00008, 16'h0000, 1'b1, 16'h00A5, 2'h3);
    add(OP_SEC_LOCK, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h3);
    add(OP_SEC_PROGRAM, 20'h00009, 16'h0000, 1'b1, 16'h0000, 2'h3);
    add(OP_READ, 20'h00009, 16'h0000, 1'b1, 16'hFFFF, 2'h3);
    add(OP_MODE_EXIT, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_PROGRAM, 20'h00800, 16'h5555, 1'b1, 16'h0000, 2'h0);
    add(OP_SECTOR_ERASE, 20'h00FFF, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'h00800, 16'h0000, 1'b1, 16'hFFFF, 2'h0);
    add(OP_READ, 20'h00100, 16'h0000, 1'b1, 16'h1234, 2'h0);
    add(OP_BLOCK_ERASE, 20'h07FFF, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'h00100, 16'h0000, 1'b1, 16'hFFFF, 2'h0);
    add(OP_PROGRAM, 20'hFF000, 16'h0000, 1'b0, 16'h0000, 2'h0);
    add(OP_READ, 20'hFF000, 16'h0000, 1'b0, 16'hFFFF, 2'h0);
    add(OP_PROGRAM, 20'hFF000, 16'h00C3, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'hFF000, 16'h0000, 1'b1, 16'h00C3, 2'h0);
    add(OP_PROGRAM, 20'hFC010, 16'h0042, 1'b1, 16'h0000, 2'h0);
    add(OP_BLOCK_ERASE, 20'hFD000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'hFC010, 16'h0000, 1'b1, 16'h0042, 2'h0);
    add(OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    add(OP_READ, 20'hFF000, 16'h0000, 1'b1, 16'hFFFF, 2'h0);
    add(OP_SEC_ENTRY, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h3);
    add(OP_READ, 20'h00008, 16'h0000, 1'b1, 16'h00A5, 2'h3);
    add(OP_MODE_EXIT, 20'h00000, 16'h0000, 1'b1, 16'h0000, 2'h0);
    foreach (rows[i])
    begin
      wp_level <= rows[i].wp;
      do_op(rows[i].op, rows[i].a, rows[i].d, rf);
      check(16'(ack), 16'h0001);
      if (rows[i].op == OP_READ) check(rdata, rows[i].e);
      check(16'(mode), 16'(rows[i].md));
    end
    do_op(OP_MODE_EXIT, 20'h00000, 16'h0000, rf);
    check(16'(rf), 16'h0001);
    do_op(OP_ID_ENTRY, 20'h00000, 16'h0000, rf);
    do_op(OP_PROGRAM, 20'h00100, 16'h0000, rf);
    check(16'(rf), 16'h0001);
    do_op(OP_CFI_SHORT, 20'h00000, 16'h0000, rf);
    check(16'(rf), 16'h0001);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    check({14'h0000, mode}, 16'h0000);
    check(16'({fl_rst_b, fl_ce_b}), 16'h0001);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    req  <= 1'b1;
    op   <= OP_PROGRAM;
    addr <= 20'h00200;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    while (rdy !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'({rdy, busy}), 16'h0001);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    check(16'({rdy, busy}), 16'h0002);
    @(posedge clk);
    rst_b <= 1'b1;
    do_op(OP_READ, 20'h00000, 16'h0000, rf);
    check(rdata, 16'hFFFF);
    results();
  end
endmodule
